// File: rtl/mvic_ctrl.sv
// vectored interrupt controller: arbitration, context stacking, wake, pin groups
`timescale 1ns/10ps
`default_nettype none
module mvic_ctrl (
	input wire logic clk_i, // cpu clock
	input wire logic rst_i, // async reset, high
	input wire logic instr_end_i, // current instruction done
	input wire logic trap_i, // trap instruction executed
	input wire logic return_from_irq_instr_i, // return instruction
	input wire logic mask_set_i, // software sets mask
	input wire logic mask_clr_i, // software clears mask
	input wire logic wfi_i, // enter wait mode
	input wire logic halt_i, // enter halt mode
	input wire logic [15:0] pc_i, // program counter
	input wire logic [7:0] x_i, // index register
	input wire logic [7:0] a_i, // accumulator
	input wire logic [7:0] condition_code_reg_i, // flags
	input wire logic [7:0] stk_rdata_i, // stack read data
	input wire logic [3:0] porta_i, // port A pins 0-3
	input wire logic [2:0] portf_i, // port F pins 0-2
	input wire logic [7:0] portb_i, // port B pins
	input wire logic [3:0] porta_ien_i, // pin irq enables
	input wire logic [2:0] portf_ien_i, // pin irq enables
	input wire logic [7:0] portb_ien_i, // pin irq enables
	input wire logic [1:0] ext_polarity_lo_pair_i, // lines 0,1
	input wire logic [1:0] ext_polarity_hi_pair_i, // lines 2,3
	input wire logic serial_periph_xfer_done_flag_i, // spi flag
	input wire logic serial_periph_mode_fault_flag_i, // spi flag
	input wire logic [4:0] tima_flags_i, // timer A flags
	input wire logic [4:0] timb_flags_i, // timer B flags
	input wire logic [4:0] sci_flags_i, // async serial flags
	input wire logic [3:0] per_ien_i, // sci,timb,tima,spi enables
	input wire logic [3:0] per_clr_i, // clearing sequence done
	output logic busy_o, // core stalled
	output logic stk_we_o, // stack write
	output logic stk_re_o, // stack read
	output logic [15:0] stk_addr_o, // stack address
	output logic [7:0] stk_wdata_o, // stack write data
	output logic pc_load_o, // load pc_o
	output logic [15:0] pc_o, // new program counter
	output logic restore_o, // load restored context
	output logic [7:0] x_o, // restored index
	output logic [7:0] a_o, // restored accumulator
	output logic [7:0] condition_code_reg_o, // restored flags
	output logic i_bit_o, // global mask bit
	output logic wait_o, // in wait mode
	output logic halt_o, // in halt mode
	output logic [3:0] ext_irq_line_o // external requests
);
	mvic_pkg::mvic_state_t st_r;
	mvic_pkg::mvic_lp_t lp_r;
	logic [14:0] pin_s1_r, pin_s2_r;
	logic [3:0] comb, act, prev_r, fall, rise, lvl, edge_ev, pol_chg, ext_pend_r, ext_req, ack;
	logic [1:0] pol_lo_r, pol_hi_r;
	logic [3:0] pf, pf_prev_r, plat_r, preq;
	logic trap_pend_r, i_bit_r, take, lp_wake;
	logic [7:0] elig;
	logic [8:0] cand;
	logic [3:0] sel_w, sel_r;
	logic [7:0] sp_r;
	logic [2:0] cnt_r;
	logic [15:0] c_pc;
	logic [7:0] c_x, c_a, c_cc;
	logic [15:0] pc_r;
	logic pc_ld_r, rst_done_r;

	// lowest index wins
	function automatic logic [3:0] first_src(input logic [8:0] r);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 8; i >= 0; i--) begin
			if (r[i]) begin
				s = 4'(i);
			end
		end
		return s;
	endfunction : first_src

	// vector table
	function automatic logic [15:0] vec_of(input logic [3:0] s);
		case (s)
			4'h0: vec_of = mvic_pkg::VEC_TRAP;
			4'h1: vec_of = mvic_pkg::VEC_EXT0;
			4'h2: vec_of = mvic_pkg::VEC_EXT1;
			4'h3: vec_of = mvic_pkg::VEC_EXT2;
			4'h4: vec_of = mvic_pkg::VEC_EXT3;
			4'h5: vec_of = mvic_pkg::VEC_SPI;
			4'h6: vec_of = mvic_pkg::VEC_TIMA;
			4'h7: vec_of = mvic_pkg::VEC_TIMB;
			default: vec_of = mvic_pkg::VEC_SCI;
		endcase
	endfunction : vec_of

	// two-stage pin synchroniser
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_r <= mvic_pkg::PIN_IDLE;
			pin_s2_r <= mvic_pkg::PIN_IDLE;
		end else begin
			pin_s1_r <= {portb_i, portf_i, porta_i};
			pin_s2_r <= pin_s1_r;
		end
	end

	// pin groups ANDed, disabled pins read as high
	assign comb[0] = &(pin_s2_r[3:0] | ~porta_ien_i);
	assign comb[1] = &(pin_s2_r[6:4] | ~portf_ien_i);
	assign comb[2] = &(pin_s2_r[10:7] | ~portb_ien_i[3:0]);
	assign comb[3] = &(pin_s2_r[14:11] | ~portb_ien_i[7:4]);
	assign act = {|portb_ien_i[7:4], |portb_ien_i[3:0], |portf_ien_i, |porta_ien_i};
	assign fall = prev_r & ~comb;
	assign rise = ~prev_r & comb;
	assign pol_chg = {{2{pol_hi_r != ext_polarity_hi_pair_i}}, {2{pol_lo_r != ext_polarity_lo_pair_i}}};

	// group history and polarity history
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_r <= 4'hf;
			pol_lo_r <= mvic_pkg::POL_RST;
			pol_hi_r <= mvic_pkg::POL_RST;
		end else begin
			prev_r <= comb;
			pol_lo_r <= ext_polarity_lo_pair_i;
			pol_hi_r <= ext_polarity_hi_pair_i;
		end
	end

	// per-line detector: upper bit falls, lower bit rises, 00 is low level
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_ext
			logic [1:0] p;
			assign p = (k < 2) ? ext_polarity_lo_pair_i : ext_polarity_hi_pair_i;
			assign edge_ev[k] = act[k] & ((p[1] & fall[k]) | (p[0] & rise[k]));
			assign lvl[k] = act[k] & (p == 2'h0) & ~comb[k];
			assign ext_req[k] = ext_pend_r[k] | lvl[k];
			assign ack[k] = take & (sel_w == mvic_pkg::SRC_EXT0 + 4'(k));
			// latched edge, new event wins over clear
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					ext_pend_r[k] <= 1'b0;
				end else if (edge_ev[k]) begin
					ext_pend_r[k] <= 1'b1;
				end else if (ack[k] | pol_chg[k]) begin
					ext_pend_r[k] <= 1'b0;
				end
			end
		end
	endgenerate
	assign ext_irq_line_o = ext_req;

	// peripheral flag groups sharing one vector each
	assign pf = {|sci_flags_i, |timb_flags_i, |tima_flags_i,
		serial_periph_xfer_done_flag_i | serial_periph_mode_fault_flag_i};
	generate
		for (k = 0; k < 4; k++) begin : g_per
			// pending latch, new flag wins over clearing sequence
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					plat_r[k] <= 1'b0;
					pf_prev_r[k] <= 1'b0;
				end else begin
					pf_prev_r[k] <= pf[k];
					if (pf[k] & ~pf_prev_r[k]) begin
						plat_r[k] <= 1'b1;
					end else if (per_clr_i[k]) begin
						plat_r[k] <= 1'b0;
					end
				end
			end
			assign preq[k] = per_ien_i[k] & (plat_r[k] | pf[k]);
		end
	endgenerate

	// arbitration: halt admits external lines only, mask gates maskables
	assign elig = (lp_r == mvic_pkg::LP_HALT) ? {4'h0, ext_req} : {preq, ext_req};
	assign lp_wake = (lp_r == mvic_pkg::LP_WAIT) ? |{preq, ext_req} : (lp_r == mvic_pkg::LP_HALT) & (|ext_req);
	assign cand = {elig & {8{~i_bit_r}}, trap_pend_r & (lp_r == mvic_pkg::LP_RUN)};
	assign sel_w = first_src(cand);
	assign take = (st_r == mvic_pkg::ST_IDLE) & (|cand) & (instr_end_i | lp_wake);

	// trap stays pending until its entry
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			trap_pend_r <= 1'b0;
		end else if (trap_i) begin
			trap_pend_r <= 1'b1;
		end else if (take & (sel_w == mvic_pkg::SRC_TRAP)) begin
			trap_pend_r <= 1'b0;
		end
	end

	// low-power mode tracking
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lp_r <= mvic_pkg::LP_RUN;
		end else if (take) begin
			lp_r <= mvic_pkg::LP_RUN;
		end else if (halt_i) begin
			lp_r <= mvic_pkg::LP_HALT;
		end else if (wfi_i) begin
			lp_r <= mvic_pkg::LP_WAIT;
		end
	end

	// global mask bit
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			i_bit_r <= mvic_pkg::I_RST;
		end else if (take) begin
			i_bit_r <= 1'b1;
		end else if (st_r == mvic_pkg::ST_POP && cnt_r == 3'h0) begin
			i_bit_r <= stk_rdata_i[mvic_pkg::I_BIT];
		end else if (wfi_i | halt_i | mask_clr_i) begin
			i_bit_r <= 1'b0;
		end else if (mask_set_i) begin
			i_bit_r <= 1'b1;
		end
	end

	// entry and return sequencer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= mvic_pkg::ST_RSTV;
			cnt_r <= 3'h0;
			sp_r <= mvic_pkg::SP_RST;
			sel_r <= 4'h0;
			c_pc <= 16'h0000;
			c_x <= 8'h00;
			c_a <= 8'h00;
			c_cc <= 8'h00;
			pc_r <= 16'h0000;
			pc_ld_r <= 1'b0;
			rst_done_r <= 1'b0;
		end else begin
			pc_ld_r <= 1'b0;
			rst_done_r <= 1'b0;
			case (st_r)
				mvic_pkg::ST_RSTV: begin
					pc_r <= mvic_pkg::VEC_RESET;
					pc_ld_r <= 1'b1;
					st_r <= mvic_pkg::ST_IDLE;
				end
				mvic_pkg::ST_IDLE: begin
					cnt_r <= 3'h0;
					if (take) begin
						sel_r <= sel_w;
						c_pc <= pc_i;
						c_x <= x_i;
						c_a <= a_i;
						c_cc <= condition_code_reg_i;
						c_cc[mvic_pkg::I_BIT] <= i_bit_r;
						st_r <= mvic_pkg::ST_PUSH;
					end else if (return_from_irq_instr_i) begin
						st_r <= mvic_pkg::ST_POP;
					end
				end
				mvic_pkg::ST_PUSH: begin
					sp_r <= sp_r - 8'h01;
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == mvic_pkg::CTX_LAST) begin
						st_r <= mvic_pkg::ST_VEC;
					end
				end
				mvic_pkg::ST_VEC: begin
					pc_r <= vec_of(sel_r);
					pc_ld_r <= 1'b1;
					st_r <= mvic_pkg::ST_IDLE;
				end
				mvic_pkg::ST_POP: begin
					sp_r <= sp_r + 8'h01;
					cnt_r <= cnt_r + 3'h1;
					case (cnt_r)
						3'h0: c_cc <= stk_rdata_i;
						3'h1: c_a <= stk_rdata_i;
						3'h2: c_x <= stk_rdata_i;
						3'h3: c_pc[15:8] <= stk_rdata_i;
						default: c_pc[7:0] <= stk_rdata_i;
					endcase
					if (cnt_r == mvic_pkg::CTX_LAST) begin
						st_r <= mvic_pkg::ST_RDONE;
					end
				end
				mvic_pkg::ST_RDONE: begin
					pc_r <= c_pc;
					pc_ld_r <= 1'b1;
					rst_done_r <= 1'b1;
					st_r <= mvic_pkg::ST_IDLE;
				end
				default: st_r <= mvic_pkg::ST_IDLE;
			endcase
		end
	end

	// stack port: low pc byte first, pop pre-increments
	always_comb begin
		case (cnt_r)
			3'h0: stk_wdata_o = c_pc[7:0];
			3'h1: stk_wdata_o = c_pc[15:8];
			3'h2: stk_wdata_o = c_x;
			3'h3: stk_wdata_o = c_a;
			default: stk_wdata_o = c_cc;
		endcase
	end
	assign stk_we_o = (st_r == mvic_pkg::ST_PUSH);
	assign stk_re_o = (st_r == mvic_pkg::ST_POP);
	assign stk_addr_o = {mvic_pkg::SP_PAGE, stk_re_o ? sp_r + 8'h01 : sp_r};
	assign busy_o = (st_r != mvic_pkg::ST_IDLE);
	assign pc_load_o = pc_ld_r;
	assign pc_o = pc_r;
	assign restore_o = rst_done_r;
	assign x_o = c_x;
	assign a_o = c_a;
	assign condition_code_reg_o = c_cc;
	assign i_bit_o = i_bit_r;
	assign wait_o = (lp_r == mvic_pkg::LP_WAIT);
	assign halt_o = (lp_r == mvic_pkg::LP_HALT);

	// checks
	AST_MASKED_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!busy_o && i_bit_r && !trap_pend_r |=> !stk_we_o) else $error("maskable entry while masked");
	AST_ENTRY_SEQ: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> stk_we_o [*5] ##2 pc_load_o && pc_o == vec_of($past(sel_r))) else $error("entry sequence broken");
	AST_MASK_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> i_bit_r [*6]) else $error("mask not set on entry");
	AST_PCL_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> stk_wdata_o == $past(pc_i[7:0]) && stk_addr_o[7:0] == $past(sp_r)) else $error("first push not pc low");
	AST_TRAP_VEC: assert property (@(posedge clk_i) disable iff (rst_i)
		take && sel_w == mvic_pkg::SRC_TRAP |-> ##7 pc_load_o && pc_o == mvic_pkg::VEC_TRAP) else $error("trap vector wrong");
	AST_HALT_STAYS: assert property (@(posedge clk_i) disable iff (rst_i)
		lp_r == mvic_pkg::LP_HALT && ext_req == 4'h0 && !halt_i && !wfi_i |=> lp_r == mvic_pkg::LP_HALT)
		else $error("halt left without external request");
	AST_EDGE_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
		ack[0] && !edge_ev[0] |=> !ext_pend_r[0]) else $error("edge request not cleared on entry");
	AST_POL_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		pol_chg[3] && !edge_ev[3] |=> !ext_pend_r[3]) else $error("polarity change kept request");
	AST_LP_UNMASK: assert property (@(posedge clk_i) disable iff (rst_i)
		(wfi_i || halt_i) && !take && st_r == mvic_pkg::ST_IDLE |=> !i_bit_r) else $error("low power kept mask");
	AST_RETURN: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r == mvic_pkg::ST_IDLE && return_from_irq_instr_i && !take |=> stk_re_o [*5] ##2 restore_o)
		else $error("return sequence broken");
	AST_PER_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		per_clr_i[1] && !(pf[1] && !pf_prev_r[1]) |=> !plat_r[1]) else $error("clear kept pending latch");
endmodule : mvic_ctrl
`default_nettype wire

// File: include/mvic_pkg.sv
// shared constants and types of the vectored interrupt controller
package mvic_pkg;
	// vector addresses, highest priority first
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_TRAP = 16'hfffc;
	localparam logic [15:0] VEC_EXT0 = 16'hfff6;
	localparam logic [15:0] VEC_EXT1 = 16'hfff4;
	localparam logic [15:0] VEC_EXT2 = 16'hfff2;
	localparam logic [15:0] VEC_EXT3 = 16'hfff0;
	localparam logic [15:0] VEC_SPI = 16'hffec;
	localparam logic [15:0] VEC_TIMA = 16'hffea;
	localparam logic [15:0] VEC_TIMB = 16'hffe8;
	localparam logic [15:0] VEC_SCI = 16'hffe6;
	// source indices into the request vector
	localparam logic [3:0] SRC_TRAP = 4'h0;
	localparam logic [3:0] SRC_EXT0 = 4'h1;
	localparam logic [3:0] SRC_PER0 = 4'h5;
	// stack and context
	localparam logic [7:0] SP_PAGE = 8'h01;
	localparam logic [7:0] SP_RST = 8'hff;
	localparam logic [2:0] CTX_LAST = 3'h4;
	localparam int I_BIT = 3;
	localparam logic I_RST = 1'b1;
	// external trigger selection per polarity pair
	localparam logic [1:0] POL_RST = 2'h0;
	localparam logic [14:0] PIN_IDLE = 15'h7fff;
	typedef enum logic [2:0] {ST_RSTV, ST_IDLE, ST_PUSH, ST_VEC, ST_POP, ST_RDONE} mvic_state_t;
	typedef enum logic [1:0] {LP_RUN, LP_WAIT, LP_HALT} mvic_lp_t;
endpackage : mvic_pkg

// File: testbench/mvic_stack_model.sv
// stack ram model standing in for the core's data memory
`timescale 1ns/10ps
`default_nettype none
module mvic_stack_model (
	input wire logic clk_i, // cpu clock
	input wire logic we_i, // stack write
	input wire logic re_i, // stack read
	input wire logic [15:0] addr_i, // stack address
	input wire logic [7:0] wdata_i, // write data
	output logic [7:0] rdata_o // read data
);
	logic [7:0] mem_r [256];
	logic [7:0] last_r = 8'h5a;
	// one byte per push within the fixed stack page
	always @(posedge clk_i) begin
		if (we_i) begin
			mem_r[addr_i[7:0]] <= wdata_i;
		end
		if (re_i) begin
			last_r <= mem_r[addr_i[7:0]];
		end
	end
	// released bus shows the inverse of the last byte, never a stale copy
	assign rdata_o = re_i ? mem_r[addr_i[7:0]] : ~last_r;
endmodule : mvic_stack_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_i = 0, rst_i = 1, instr_end_i = 1, trap_i = 0, return_from_irq_instr_i = 0;
	logic mask_set_i = 0, mask_clr_i = 0, wfi_i = 0, halt_i = 0;
	logic [15:0] pc_i = 16'h1234;
	logic [7:0] x_i = 8'h56, a_i = 8'h9a, condition_code_reg_i = 8'h01, stk_rdata_i;
	logic [3:0] porta_i = 4'hf, porta_ien_i = 0, per_ien_i = 0, per_clr_i = 0;
	logic [2:0] portf_i = 3'h7, portf_ien_i = 0;
	logic [7:0] portb_i = 8'hff, portb_ien_i = 0;
	logic [1:0] ext_polarity_lo_pair_i = 0, ext_polarity_hi_pair_i = 0;
	logic serial_periph_xfer_done_flag_i = 0, serial_periph_mode_fault_flag_i = 0;
	logic [4:0] tima_flags_i = 0, timb_flags_i = 0, sci_flags_i = 0;
	logic busy_o, stk_we_o, stk_re_o, pc_load_o, restore_o, i_bit_o, wait_o, halt_o;
	logic [15:0] stk_addr_o, pc_o;
	logic [7:0] stk_wdata_o, x_o, a_o, condition_code_reg_o;
	logic [3:0] ext_irq_line_o;
	logic [15:0] wa [5];
	logic [7:0] wd [5];
	int nw = 0, nr = 0, n_errors = 0, checks = 0;

	mvic_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .instr_end_i(instr_end_i), .trap_i(trap_i),
		.return_from_irq_instr_i(return_from_irq_instr_i), .mask_set_i(mask_set_i), .mask_clr_i(mask_clr_i),
		.wfi_i(wfi_i), .halt_i(halt_i), .pc_i(pc_i), .x_i(x_i), .a_i(a_i),
		.condition_code_reg_i(condition_code_reg_i), .stk_rdata_i(stk_rdata_i), .porta_i(porta_i),
		.portf_i(portf_i), .portb_i(portb_i), .porta_ien_i(porta_ien_i), .portf_ien_i(portf_ien_i),
		.portb_ien_i(portb_ien_i), .ext_polarity_lo_pair_i(ext_polarity_lo_pair_i),
		.ext_polarity_hi_pair_i(ext_polarity_hi_pair_i),
		.serial_periph_xfer_done_flag_i(serial_periph_xfer_done_flag_i),
		.serial_periph_mode_fault_flag_i(serial_periph_mode_fault_flag_i), .tima_flags_i(tima_flags_i),
		.timb_flags_i(timb_flags_i), .sci_flags_i(sci_flags_i), .per_ien_i(per_ien_i), .per_clr_i(per_clr_i),
		.busy_o(busy_o), .stk_we_o(stk_we_o), .stk_re_o(stk_re_o), .stk_addr_o(stk_addr_o),
		.stk_wdata_o(stk_wdata_o), .pc_load_o(pc_load_o), .pc_o(pc_o), .restore_o(restore_o), .x_o(x_o),
		.a_o(a_o), .condition_code_reg_o(condition_code_reg_o), .i_bit_o(i_bit_o), .wait_o(wait_o),
		.halt_o(halt_o), .ext_irq_line_o(ext_irq_line_o));
	mvic_stack_model stack (.clk_i(clk_i), .we_i(stk_we_o), .re_i(stk_re_o), .addr_i(stk_addr_o),
		.wdata_i(stk_wdata_o), .rdata_o(stk_rdata_i));

	// cpu clock, 10 ns period
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// records the bytes pushed by one entry
	always @(posedge clk_i) begin
		if (stk_we_o === 1'b1 && nw < 5) begin
			wa[nw] = stk_addr_o;
			wd[nw] = stk_wdata_o;
			nw++;
		end
		if (stk_re_o === 1'b1) begin
			nr++;
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	task automatic clr_mask;
		@(posedge clk_i) mask_clr_i <= 1'b1;
		@(posedge clk_i) mask_clr_i <= 1'b0;
	endtask : clr_mask
	task automatic pulse_clr(input logic [3:0] m);
		@(posedge clk_i) per_clr_i <= m;
		@(posedge clk_i) per_clr_i <= 4'h0;
	endtask : pulse_clr
	// waits for the vector load and checks vector and mask
	task automatic expect_entry(input logic [15:0] vec);
		for (int k = 0; k < 60 && pc_load_o !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		check(pc_o, vec);
		check(busy_o, 1'b0);
		check(i_bit_o, 1'b1);
	endtask : expect_entry
	task automatic expect_none(input int n);
		logic bad;
		bad = 0;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			if (stk_we_o !== 1'b0 || pc_load_o !== 1'b0) bad = 1;
		end
		check(bad, 1'b0);
	endtask : expect_none

	task automatic do_reset;
		tick(20);
		check(i_bit_o, 1'b1);
		@(posedge clk_i) rst_i <= 1'b0;
		expect_entry(mvic_pkg::VEC_RESET);
	endtask : do_reset
	task automatic masked_entry_return;
		logic [7:0] exp_b [5] = '{8'h34, 8'h12, 8'h56, 8'h9a, 8'h01};
		@(posedge clk_i) porta_ien_i <= 4'h1;
		porta_i <= 4'he;
		expect_none(10);
		check(ext_irq_line_o, 4'h1);
		nw = 0;
		clr_mask();
		expect_entry(mvic_pkg::VEC_EXT0);
		for (int k = 0; k < 5; k++) begin
			check(wa[k], 16'h01ff - 16'(k));
			check(wd[k], exp_b[k]);
		end
		@(posedge clk_i) porta_i <= 4'hf;
		tick(5);
		check(ext_irq_line_o[0], 1'b0);
		nr = 0;
		@(posedge clk_i) return_from_irq_instr_i <= 1'b1;
		@(posedge clk_i) return_from_irq_instr_i <= 1'b0;
		for (int k = 0; k < 20 && restore_o !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		check(pc_o, 16'h1234);
		check(16'(nr), 16'h0005);
		check({x_o, a_o}, 16'h569a);
		check({condition_code_reg_o, 7'h0, i_bit_o}, 16'h0100);
	endtask : masked_entry_return
	task automatic priority_and_clear;
		@(posedge clk_i) mask_set_i <= 1'b1;
		instr_end_i <= 1'b0;
		@(posedge clk_i) mask_set_i <= 1'b0;
		trap_i <= 1'b1;
		portf_ien_i <= 3'h1;
		portf_i <= 3'h6;
		sci_flags_i <= 5'h01;
		per_ien_i <= 4'h8;
		tima_flags_i <= 5'h04;
		@(posedge clk_i) trap_i <= 1'b0;
		tima_flags_i <= 5'h00;
		expect_none(10);
		@(posedge clk_i) instr_end_i <= 1'b1;
		expect_entry(mvic_pkg::VEC_TRAP);
		clr_mask();
		expect_entry(mvic_pkg::VEC_EXT1);
		@(posedge clk_i) portf_i <= 3'h7;
		tick(5);
		clr_mask();
		expect_entry(mvic_pkg::VEC_SCI);
		@(posedge clk_i) sci_flags_i <= 5'h00;
		pulse_clr(4'ha);
		@(posedge clk_i) per_ien_i <= 4'ha;
		clr_mask();
		expect_none(15);
	endtask : priority_and_clear
	task automatic halt_wake;
		@(posedge clk_i) halt_i <= 1'b1;
		ext_polarity_hi_pair_i <= 2'h1;
		portb_ien_i <= 8'h03;
		@(posedge clk_i) halt_i <= 1'b0;
		sci_flags_i <= 5'h10;
		portb_i <= 8'hfc;
		tick(2);
		check({halt_o, i_bit_o}, 2'b10);
		expect_none(20);
		@(posedge clk_i) portb_i <= 8'hfd;
		expect_none(10);
		@(posedge clk_i) portb_i <= 8'hff;
		expect_entry(mvic_pkg::VEC_EXT2);
		check(halt_o, 1'b0);
		@(posedge clk_i) sci_flags_i <= 5'h00;
		pulse_clr(4'h8);
	endtask : halt_wake
	task automatic wait_wake;
		@(posedge clk_i) wfi_i <= 1'b1;
		@(posedge clk_i) wfi_i <= 1'b0;
		tick(2);
		check({wait_o, i_bit_o}, 2'b10);
		@(posedge clk_i) tima_flags_i <= 5'h10;
		expect_entry(mvic_pkg::VEC_TIMA);
		check(wait_o, 1'b0);
		@(posedge clk_i) tima_flags_i <= 5'h00;
		pulse_clr(4'h2);
	endtask : wait_wake
	task automatic edge_modes;
		@(posedge clk_i) ext_polarity_lo_pair_i <= 2'h2;
		tick(3);
		@(posedge clk_i) porta_i <= 4'he;
		tick(6);
		check(ext_irq_line_o[0], 1'b1);
		@(posedge clk_i) ext_polarity_lo_pair_i <= 2'h3;
		tick(2);
		check(ext_irq_line_o[0], 1'b0);
		@(posedge clk_i) porta_i <= 4'hf;
		tick(6);
		check(ext_irq_line_o[0], 1'b1);
		clr_mask();
		expect_entry(mvic_pkg::VEC_EXT0);
		check(ext_irq_line_o[0], 1'b0);
		clr_mask();
		expect_none(10);
	endtask : edge_modes
	// line-3 edge, spi and timer b, served by falling priority
	task automatic low_priority;
		@(posedge clk_i) mask_set_i <= 1'b1;
		ext_polarity_hi_pair_i <= 2'h2;
		portb_ien_i <= 8'h10;
		per_ien_i <= 4'h5;
		@(posedge clk_i) mask_set_i <= 1'b0;
		portb_i <= 8'hef;
		serial_periph_mode_fault_flag_i <= 1'b1;
		timb_flags_i <= 5'h02;
		tick(6);
		check(ext_irq_line_o, 4'h8);
		clr_mask();
		expect_entry(mvic_pkg::VEC_EXT3);
		clr_mask();
		expect_entry(mvic_pkg::VEC_SPI);
		@(posedge clk_i) serial_periph_mode_fault_flag_i <= 1'b0;
		pulse_clr(4'h1);
		clr_mask();
		expect_entry(mvic_pkg::VEC_TIMB);
		@(posedge clk_i) timb_flags_i <= 5'h00;
		pulse_clr(4'h4);
	endtask : low_priority

	task automatic summarize;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	// cuts a hang short well beyond the expected run
	initial begin
		#200000;
		n_errors++;
		summarize();
	end
	// main sequence
	initial begin
		do_reset();
		masked_entry_return();
		priority_and_clear();
		halt_wake();
		wait_wake();
		edge_modes();
		low_priority();
		summarize();
	end
endmodule : tb
`default_nettype wire
